// [core/dac_host.sv]
// host that drives a quad converter parallel port from AXI4-Lite commands
// assumes device pins are wired by the bench; two-way data pins resolved outside
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`include "dac_host_map.svh"
module dac_host
	import dac_host_pkg::*;
#(
	parameter int DATA_W = 10 // converter data width
)
(
	input  wire logic              aclk,               // clock, 250 MHz
	input  wire logic              aresetn,            // sync reset, active low
	input  wire logic              clk_en,             // freezes all state when low
	input  wire logic [7:0]        s_axi_awaddr,       // write address
	input  wire logic              s_axi_awvalid,      // write address valid
	output logic                   s_axi_awready,      // write address ready
	input  wire logic [31:0]       s_axi_wdata,        // write data
	input  wire logic [3:0]        s_axi_wstrb,        // write strobes
	input  wire logic              s_axi_wvalid,       // write data valid
	output logic                   s_axi_wready,       // write data ready
	output logic [1:0]             s_axi_bresp,        // write response
	output logic                   s_axi_bvalid,       // write response valid
	input  wire logic              s_axi_bready,       // write response ready
	input  wire logic [7:0]        s_axi_araddr,       // read address
	input  wire logic              s_axi_arvalid,      // read address valid
	output logic                   s_axi_arready,      // read address ready
	output logic [31:0]            s_axi_rdata,        // read data
	output logic [1:0]             s_axi_rresp,        // read response
	output logic                   s_axi_rvalid,       // read data valid
	input  wire logic              s_axi_rready,       // read data ready
	input  wire logic [DATA_W-1:0] data_bus_i,         // data pins in
	output logic [DATA_W-1:0]      data_bus_o,         // data pins out
	output logic                   data_bus_oe_n,      // low while host drives data
	output logic                   channel_select_low, // channel code bit 0
	output logic                   channel_select_high,// channel code bit 1
	output logic                   read_write,         // 1 read, 0 write
	output logic                   chip_select_n,      // device select, active low
	output logic                   output_load_n,      // load strobe, active low
	output logic                   reset_strobe_n,     // device reset, active low
	output logic                   reset_scale         // 1 midscale reset, 0 zero
);

	// ----------------------------------------
	// timing counts
	// ----------------------------------------
	localparam logic [7:0] SETUP_CYC = 8'(`NS_TO_CYC(`T_SETUP_NS));
	localparam logic [7:0] WRITE_CYC = 8'(`NS_TO_CYC(`T_WRITE_NS));
	localparam logic [7:0] READ_CYC  = 8'(`NS_TO_CYC(`T_READ_NS));
	localparam logic [7:0] LOAD_CYC  = 8'(`NS_TO_CYC(`T_LOAD_NS));
	localparam logic [7:0] RESET_CYC = 8'(`NS_TO_CYC(`T_RESET_NS));
	localparam logic [7:0] HIZ_CYC   = 8'(`NS_TO_CYC(`T_HIZ_NS));
	localparam logic [7:0] GAP_CYC   = 8'(`NS_TO_CYC(`T_GAP_NS));

	state_t              state_q, state_d;
	op_t                 op_q;
	logic [1:0]          chan_q;
	logic [DATA_W-1:0]   wdat_q;
	logic [7:0]          cnt_q;
	logic [DATA_W-1:0]   rb_q;
	logic [1:0]          cfg_q;
	logic                done_q;
	logic                aw_hold_q, w_hold_q;
	logic [7:0]          awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                bvalid_q, rvalid_q;
	logic [31:0]         rdata_q;
	logic [DATA_W-1:0]   sync1_q, sync2_q, sync3_q;

	// ----------------------------------------
	// bus slave decode
	// ----------------------------------------
	wire busy     = (state_q != ST_IDLE);
	wire both_in  = aw_hold_q && w_hold_q;
	wire hit_cmd  = (awaddr_q == `REG_CMD);
	wire hit_cfg  = (awaddr_q == `REG_CONFIG);
	wire wr_known = hit_cmd || hit_cfg;
	// command write while busy waits until the port is free: no command is lost
	wire wr_fire  = both_in && !bvalid_q && (!hit_cmd || !busy);
	wire cmd_go   = wr_fire && hit_cmd && (wstrb_q[2] || wstrb_q[0]);
	wire [2:0] op_field = wdata_q[`CMD_OP_LSB +: 3];
	wire op_ok    = (op_field <= 3'h4);
	wire rd_fire  = s_axi_arvalid && !rvalid_q;
	wire [31:0] status_word = {30'h0, done_q, busy};
	wire [31:0] rd_word =
		(s_axi_araddr == `REG_STATUS)   ? status_word :
		(s_axi_araddr == `REG_READBACK) ? {22'h0, rb_q} :
		(s_axi_araddr == `REG_CONFIG)   ? {30'h0, cfg_q} :
		(s_axi_araddr == `REG_CMD)      ? {9'h0, op_q, 2'h0, chan_q, 6'h0, wdat_q} : 32'h0;
	wire rd_known = (s_axi_araddr == `REG_STATUS) || (s_axi_araddr == `REG_READBACK) ||
		(s_axi_araddr == `REG_CONFIG) || (s_axi_araddr == `REG_CMD);

	// frozen slave shows no handshake, else a beat would be taken and lost
	assign s_axi_awready = !aw_hold_q && clk_en;
	assign s_axi_wready  = !w_hold_q && clk_en;
	assign s_axi_bvalid  = bvalid_q && clk_en;
	assign s_axi_rvalid  = rvalid_q && clk_en;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_arready = !rvalid_q && clk_en;

	logic [1:0] rresp_q, bresp_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= 2'h0;
			cfg_q     <= `CONFIG_RESET;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && !aw_hold_q)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_q)
			begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				if (hit_cfg && wstrb_q[0])
					cfg_q <= wdata_q[1:0];
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
			if (rd_fire)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= rd_known ? 2'h0 : 2'h2;
			end
			else if (rvalid_q && s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end
	// write response: unmapped address or bad op answers slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bresp_q <= 2'h0;
		else if (clk_en && wr_fire)
			bresp_q <= (!wr_known || (hit_cmd && !op_ok)) ? 2'h2 : 2'h0;
	end
	assign s_axi_bresp = bresp_q;

	// ----------------------------------------
	// readback synchroniser
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end
		else if (clk_en)
		begin
			sync1_q <= data_bus_i;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	wire rb_stable = (sync2_q == sync3_q);

	// ----------------------------------------
	// pin sequencer
	// ----------------------------------------
	wire cnt_end  = (cnt_q == 8'h00);
	wire is_write = (op_q == OP_WRITE) || (op_q == OP_WRITE_LOAD);
	wire sel_phase = (state_q == ST_SETUP) || (state_q == ST_PULSE);
	wire [7:0] pulse_cyc =
		(op_q == OP_READ)     ? READ_CYC :
		(op_q == OP_LOAD_ALL) ? LOAD_CYC :
		(op_q == OP_RESET)    ? RESET_CYC : WRITE_CYC;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:  if (cmd_go && op_ok) state_d = ST_SETUP;
			ST_SETUP: if (cnt_end) state_d = ST_PULSE;
			ST_PULSE: if (cnt_end && (op_q != OP_READ || rb_stable)) state_d = ST_GAP;
			ST_GAP:   if (cnt_end) state_d = ST_DONE;
			ST_DONE:  state_d = ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_IDLE;
			op_q    <= OP_WRITE;
			chan_q  <= 2'h0;
			wdat_q  <= '0;
			cnt_q   <= 8'h00;
			rb_q    <= '0;
			done_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			if (state_q == ST_IDLE && state_d == ST_SETUP)
			begin
				op_q   <= op_t'(op_field);
				chan_q <= wdata_q[`CMD_CHAN_LSB +: 2];
				wdat_q <= wdata_q[`CMD_DATA_LSB +: DATA_W];
				cnt_q  <= SETUP_CYC - 8'h01;
				done_q <= 1'b0;
			end
			else if (state_q == ST_SETUP && cnt_end)
				cnt_q <= pulse_cyc - 8'h01;
			else if (state_q == ST_PULSE && state_d == ST_GAP)
			begin
				// a released read bus needs the float time before the next drive
				cnt_q <= (op_q == OP_READ) ? HIZ_CYC - 8'h01 : GAP_CYC - 8'h01;
				if (op_q == OP_READ)
					rb_q <= sync3_q;
			end
			else if (!cnt_end)
				cnt_q <= cnt_q - 8'h01;
			// set wins over a new command start in the same cycle
			if (state_q == ST_DONE)
				done_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	wire sel_access = sel_phase && (is_write || op_q == OP_READ);
	// select only asserted for register accesses, never for group load or reset
	wire cs_n_d  = !sel_access;
	// single buffer pulses strobe low in the pulse phase under select; group load pulses it alone
	wire ld_n_d  = !((state_q == ST_PULSE) && (op_q == OP_WRITE_LOAD || op_q == OP_LOAD_ALL));
	// reset strobe with select high so registers stay latched after release
	wire rs_n_d  = !((state_q == ST_PULSE) && (op_q == OP_RESET));
	// host drives only for writes; during reads the device owns the bus
	wire oe_n_d  = !(sel_phase && is_write);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			chip_select_n       <= 1'b1;
			output_load_n       <= 1'b1;
			reset_strobe_n      <= 1'b1;
			data_bus_oe_n       <= 1'b1;
			data_bus_o          <= '0;
			read_write          <= 1'b1;
			channel_select_low  <= 1'b0;
			channel_select_high <= 1'b0;
			reset_scale         <= 1'b0;
		end
		else if (clk_en)
		begin
			chip_select_n       <= cs_n_d;
			output_load_n       <= ld_n_d;
			reset_strobe_n      <= rs_n_d;
			data_bus_oe_n       <= oe_n_d;
			data_bus_o          <= wdat_q;
			read_write          <= !(sel_phase && is_write);
			channel_select_low  <= chan_q[0];
			channel_select_high <= chan_q[1];
			reset_scale         <= cfg_q[`CFG_SCALE_BIT];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	cs_only_access_a: assert property (!chip_select_n |-> (sel_access || $past(sel_access)))
		else $error("select low outside an access");
	drive_only_write_a: assert property (!data_bus_oe_n |-> (read_write == 1'b0))
		else $error("host drives bus while not writing");
	read_no_drive_a: assert property ((!chip_select_n && read_write) |-> data_bus_oe_n)
		else $error("host drives bus during read");
	reset_no_cs_a: assert property (!reset_strobe_n |-> chip_select_n)
		else $error("select low during reset strobe");
	reset_width_a: assert property ((clk_en && $fell(reset_strobe_n)) |-> !reset_strobe_n [*8])
		else $error("reset strobe too short");
	load_all_cs_a: assert property ((!output_load_n && op_q == OP_LOAD_ALL) |-> chip_select_n)
		else $error("group load with select low");
	single_load_a: assert property ((!output_load_n && op_q == OP_WRITE_LOAD) |-> !chip_select_n)
		else $error("single load without select");
	plain_write_a: assert property ((op_q == OP_WRITE && busy) |-> output_load_n)
		else $error("strobe low on input-only write");
	chan_steady_a: assert property ((!chip_select_n && !$past(chip_select_n)) |-> $stable(channel_select_low))
		else $error("channel code moved during access");
	cmd_done_a: assert property ((clk_en && state_q == ST_DONE) |=> done_q)
		else $error("done not set");

	write_seen_c: cover property (!chip_select_n && !read_write && !output_load_n);
	group_load_c: cover property (!output_load_n && chip_select_n);
	read_seen_c:  cover property (state_q == ST_PULSE && op_q == OP_READ ##1 state_q == ST_GAP);
	reset_seen_c: cover property (!reset_strobe_n && reset_scale);

endmodule

// [pkg/dac_host_map.svh]
// constants for the quad converter parallel-port host: register map, fields, timing
// assumes inclusion by bare name from the package and the core
`ifndef DAC_HOST_MAP_SVH
`define DAC_HOST_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CMD        8'h00
`define REG_STATUS     8'h04
`define REG_READBACK   8'h08
`define REG_CONFIG     8'h0C

// ----------------------------------------
// fields
// ----------------------------------------
`define CMD_DATA_LSB   0
`define CMD_CHAN_LSB   16
`define CMD_OP_LSB     20
`define CFG_SCALE_BIT  0
`define CFG_AUTO_BIT   1
`define STAT_BUSY_BIT  0
`define STAT_DONE_BIT  1
`define CONFIG_RESET   2'h0
`define ZERO_CODE      10'h000
`define MID_CODE       10'h200

// ----------------------------------------
// timing, ns at 4 ns per cycle
// ----------------------------------------
`define CLK_PERIOD_NS  4
`define T_SETUP_NS     50
`define T_WRITE_NS     35
`define T_READ_NS      130
`define T_LOAD_NS      35
`define T_RESET_NS     35
`define T_HIZ_NS       100
`define T_GAP_NS       20
`define NS_TO_CYC(t)   (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [pkg/dac_host_pkg.sv]
// types for the quad converter parallel-port host
// assumes the map header sits beside this file
package dac_host_pkg;
	`include "dac_host_map.svh"

	typedef enum logic [2:0]
	{
		OP_WRITE      = 3'h0, // write input register only
		OP_WRITE_LOAD = 3'h1, // single-buffer write
		OP_LOAD_ALL   = 3'h2, // strobe with select high
		OP_READ       = 3'h3,
		OP_RESET      = 3'h4
	} op_t;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h0,
		ST_SETUP = 3'h1,
		ST_PULSE = 3'h3,
		ST_GAP   = 3'h2,
		ST_DONE  = 3'h6
	} state_t;
endpackage

// [testbench/quad_dac_model.sv]
// behavioural quad converter front end: level latches, readback drive, reset
// assumes the bench resolves the shared data pins into bus_i
module quad_dac_model
#(
	parameter int DLY = 100 // ns, read select to valid data
)
(
	input  wire logic [9:0] bus_i,   // resolved pins
	input  wire logic       ch_lo,   // channel bit 0
	input  wire logic       ch_hi,   // channel bit 1
	input  wire logic       rw,      // 1 read
	input  wire logic       cs_n,    // device select
	input  wire logic       ld_n,    // load strobe
	input  wire logic       rs_n,    // reset strobe
	input  wire logic       scale,   // midscale reset
	output logic      [9:0] bus_o,   // readback
	output logic            bus_oe_n // low while driving
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] in_q [4], dac_q [4];
	logic       rd_ok_q;
	wire  [1:0] ch = {ch_hi, ch_lo};
	wire        rd = rs_n && !cs_n && rw;
	// true latches: any input change re-evaluates, reset overrides all
	always @*
		for (int i = 0; i < 4; i++)
			if (!rs_n)
				{in_q[i], dac_q[i]} = {2{scale ? 10'h200 : 10'h000}};
			else
			begin
				if (!cs_n && !rw && ch == 2'(i))
					in_q[i] = bus_i;
				if (!ld_n && (cs_n || ch == 2'(i)))
					dac_q[i] = in_q[i];
			end
	// slow answer: data turns valid only DLY after the read starts
	always @(rd)
	begin
		rd_ok_q = 1'h0;
		if (rd)
			rd_ok_q <= #(DLY) 1'h1;
	end
	assign bus_oe_n = !rd;
	assign bus_o = rd_ok_q ? in_q[ch] : ~in_q[ch];
endmodule

// [testbench/quad_dac_parallel_port_test.sv]
// bench for the quad converter host: AXI4-Lite master, device model, reference arrays
// assumes dac_host, its package and quad_dac_model compiled first
`include "dac_host_map.svh"
module quad_dac_parallel_port_test
	import dac_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd_q;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [9:0]  float_q = 10'h155;
	logic [1:0]  resp_q;
	wire         awready, wready, bvalid, arready, rvalid, oe_n, dev_oe_n;
	wire         ch_lo, ch_hi, rw, cs_n, ld_n, rs_n, scale;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [9:0]  host_o, dev_o, bus;
	int          err_count = 0, comparisons = 0, scale_v = 0, exp_in [4], exp_dac [4];
	initial
		forever
			#2 aclk = ~aclk;
	// undriven pins wander each cycle, so stale data cannot pass
	assign bus = !oe_n ? host_o : (!dev_oe_n ? dev_o : float_q);
	always @(posedge aclk)
	begin
		float_q <= float_q + 10'h0D3;
		if (aresetn && !oe_n && !dev_oe_n)
			fail("both ends drive the data pins");
	end
	dac_host i_dac_host
	(
		.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.data_bus_i(bus), .data_bus_o(host_o), .data_bus_oe_n(oe_n),
		.channel_select_low(ch_lo), .channel_select_high(ch_hi), .read_write(rw),
		.chip_select_n(cs_n), .output_load_n(ld_n), .reset_strobe_n(rs_n), .reset_scale(scale)
	);
	quad_dac_model #(.DLY(100)) i_quad_dac_model
	(
		.bus_i(bus), .ch_lo(ch_lo), .ch_hi(ch_hi), .rw(rw), .cs_n(cs_n), .ld_n(ld_n),
		.rs_n(rs_n), .scale(scale), .bus_o(dev_o), .bus_oe_n(dev_oe_n)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want)
		begin
			err_count++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic fail(input string m);
		err_count++;
		$display("ERROR at %0t: %s", $time, m);
		conclude();
	endtask
	// both channels offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		while (!bvalid && n < 3000);
		if (n >= 3000)
			fail("write answer missing");
		resp_q = bresp;
		bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		n = 0;
		araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'h0;
		end
		while (!rvalid && n < 3000);
		if (n >= 3000)
			fail("read answer missing");
		rd_q = rdata;
		resp_q = rresp;
		rready <= 1'h0;
	endtask
	// issue one command, wait for idle, then compare device state with the reference
	task automatic run_cmd(input logic [2:0] op, input int ch, input int d);
		int n;
		axi_wr(`REG_CMD, (32'(op) << `CMD_OP_LSB) | (32'(ch) << `CMD_CHAN_LSB) | 32'(d));
		check(resp_q, (op > 3'h4) ? 32'h2 : 32'h0);
		n = 0;
		do
		begin
			axi_rd(`REG_STATUS);
			n++;
		end
		while (rd_q[`STAT_BUSY_BIT] && n < 200);
		if (n >= 200)
			fail("command never finished");
		if (op <= 3'h4)
			check(rd_q[`STAT_DONE_BIT], 32'h1);
		case (op)
			OP_WRITE:
				exp_in[ch] = d;
			OP_WRITE_LOAD:
				{exp_in[ch], exp_dac[ch]} = {d, d};
			OP_LOAD_ALL:
				exp_dac = exp_in;
			OP_RESET:
				for (int i = 0; i < 4; i++)
					{exp_in[i], exp_dac[i]} = {2{scale_v ? 32'h200 : 32'h0}};
			default:
				;
		endcase
		if (op == OP_READ)
		begin
			axi_rd(`REG_READBACK);
			check(rd_q[9:0], exp_in[ch]);
		end
		for (int i = 0; i < 4; i++)
		begin
			check(i_quad_dac_model.in_q[i], exp_in[i]);
			check(i_quad_dac_model.dac_q[i], exp_dac[i]);
		end
		check({cs_n, ld_n, rs_n, oe_n}, 32'hF);
	endtask
	initial
	begin
		void'($urandom(26));
		repeat (5)
			@(posedge aclk);
		aresetn <= 1'h1;
		check({cs_n, ld_n, rs_n, oe_n, rw}, 32'h1F);
		for (int s = 1; s >= 0; s--)
		begin
			scale_v = s;
			axi_wr(`REG_CONFIG, 32'(s));
			axi_rd(`REG_CONFIG);
			check(rd_q[`CFG_SCALE_BIT], 32'(s));
			run_cmd(OP_RESET, 0, 0);
			repeat (20)
				@(posedge aclk);
			run_cmd(OP_WRITE, s + 1, 10'h3FF);
		end
		$display("test reset codes done");
		for (int c = 0; c < 4; c++)
			run_cmd(OP_WRITE, c, $urandom % 1024);
		for (int c = 3; c >= 0; c--)
			run_cmd(OP_READ, c, 0);
		run_cmd(OP_LOAD_ALL, 0, 0);
		run_cmd(OP_WRITE_LOAD, 2, 10'h3FF);
		// freeze the host in the setup phase of a single-buffer write: pins must hold
		fork
			run_cmd(OP_WRITE_LOAD, 1, $urandom % 1024);
			begin
				repeat (12)
					@(posedge aclk);
				clk_en <= 1'h0;
				@(posedge aclk);
				check({cs_n, ld_n, rw, oe_n}, 32'h4);
				repeat (8)
					@(posedge aclk);
				check({cs_n, ld_n, rw, oe_n}, 32'h4);
				clk_en <= 1'h1;
			end
		join
		$display("test buffer modes done");
		run_cmd(3'h5, 1, 10'h001);
		run_cmd(3'h7, 3, 10'h002);
		axi_wr(8'h10, 32'h0);
		check(resp_q, 32'h2);
		axi_rd(8'h14);
		check(resp_q, 32'h2);
		check(rd_q, 32'h0);
		$display("test refusals done");
		for (int k = 0; k < 40; k++)
			run_cmd(3'($urandom % 5), $urandom % 4, $urandom % 1024);
		$display("test random mix done");
		conclude();
	end
endmodule
